// File: common/xcfg_pkg.sv
// constants shared by the crosspoint serial configuration port
// assumes a single system clock domain; link pins arrive asynchronously
// Operation
// - one active register per output holds on/off and input address, drives matrix
// - active registers change only by transfer from shadow or addressed word, or by special control pins
// - shadow bank has the active bank group layout, loaded as a serial shift register
// - while select_n high, serial clock and data are ignored, nothing shifts
// - after select_n falls, first rising clock arms, next falling edge takes bit
// - every serial bit is sampled on the falling serial clock edge
// - shifted data reaches matrix only when apply_strobe pulses high
// - apply_strobe and mode act regardless of select_n
// - apply without new data since last transfer changes nothing
// - mode high takes an addressed word and updates only that output
// - mode low takes a 16-bit frame configuring all outputs
// - frame is four 4-bit groups, address lsb first then off bit
// - addressed word is 2-bit output, 3-bit input, state bit, lsb first
// - reset loads input address 0 and turns every output off
// - broadcast_force turns every output on connected to input 0
package xcfg_pkg;
   localparam int XCFG_NUM_OUT = 4;
   localparam int XCFG_IN_W = 3;
   localparam int XCFG_OUT_W = 2;
   localparam int XCFG_GRP_W = 4;
   localparam int XCFG_FRAME_W = 16;
   localparam int XCFG_WORD_W = 6;
   localparam int XCFG_OFF_POS = 3;
   localparam int XCFG_SYNC_STAGES = 2;
   localparam logic [3:0] XCFG_GRP_RST = 4'h8;
   localparam logic [3:0] XCFG_GRP_FORCE = 4'h0;
   localparam logic [15:0] XCFG_SHADOW_RST = 16'h8888;
   localparam logic [5:0] XCFG_WORD_RST = 6'h20;
endpackage

// File: src/xcfg_sync.sv
// two-flop synchroniser for asynchronous pins
// assumes inputs come from outside the clk_sys domain
`timescale 1ns/1ps
module xcfg_sync
   import xcfg_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] q;
   } xcfg_sync_t;
   xcfg_sync_t st_ff;
   xcfg_sync_t nxt_st;
   always_comb begin
      nxt_st.meta = din;
      nxt_st.q = st_ff.meta;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign dout = st_ff.q;
endmodule

// File: src/xcfg_port.sv
// serial configuration port: shadow shift bank and per-output active bank
// assumes sclk, sdi, select_n, apply_strobe, mode, broadcast_force are async pins
// sclk must be slow against clk_sys (each level at least 3 clk_sys cycles)
`timescale 1ns/1ps
module xcfg_port
   import xcfg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic select_n,
   input wire logic apply_strobe,
   input wire logic mode,
   input wire logic broadcast_force,
   output logic serial_out,
   output logic [XCFG_NUM_OUT-1:0] out_off,
   output logic [XCFG_NUM_OUT*XCFG_IN_W-1:0] out_sel,
   output logic [XCFG_NUM_OUT-1:0] out_oe
);
   typedef enum logic [1:0] {XCFG_IDLE, XCFG_WAIT_RISE, XCFG_SHIFT} xcfg_state_t;

   typedef struct packed {
      xcfg_state_t state;
      logic sclk_d;
      logic apply_d;
      logic fresh;
      logic [XCFG_FRAME_W-1:0] shadow;
      logic [XCFG_WORD_W-1:0] word;
      logic [XCFG_NUM_OUT*XCFG_GRP_W-1:0] active;
      logic sout;
      logic [XCFG_NUM_OUT-1:0] off_q;
      logic [XCFG_NUM_OUT*XCFG_IN_W-1:0] sel_q;
      logic [XCFG_NUM_OUT-1:0] oe_q;
   } xcfg_port_t;

   logic [5:0] pins_s;
   logic sclk_s;
   logic sdi_s;
   logic sel_n_s;
   logic apply_s;
   logic mode_s;
   logic force_s;
   logic sel_a_s;
   xcfg_port_t st_ff;
   xcfg_port_t nxt_st;

   xcfg_sync #(.WIDTH(6)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      // select passes inverted so the cleared synchroniser reads as deselected after reset
      .din({sclk, serial_in, ~select_n, apply_strobe, mode, broadcast_force}),
      .dout(pins_s)
   );
   assign {sclk_s, sdi_s, sel_a_s, apply_s, mode_s, force_s} = pins_s;
   assign sel_n_s = ~sel_a_s;

   logic rise;
   logic fall;
   logic apply_p;
   logic [XCFG_OUT_W-1:0] w_out;
   assign rise = sclk_s & ~st_ff.sclk_d;
   assign fall = ~sclk_s & st_ff.sclk_d;
   assign apply_p = apply_s & ~st_ff.apply_d;
   assign w_out = st_ff.word[XCFG_OUT_W-1:0];

   always_comb begin
      nxt_st = st_ff;
      nxt_st.sclk_d = sclk_s;
      nxt_st.apply_d = apply_s;
      // apply needs no select and ignores repeats when nothing new arrived
      // it runs before the shift so a bit landing in the same cycle keeps fresh set
      if (apply_p && st_ff.fresh) begin
         nxt_st.fresh = 1'b0;
         if (mode_s) begin
            for (int o = 0; o < XCFG_NUM_OUT; o++) begin
               if (w_out == o[XCFG_OUT_W-1:0]) begin
                  nxt_st.active[o*XCFG_GRP_W +: XCFG_GRP_W] =
                     st_ff.word[XCFG_WORD_W-1:XCFG_OUT_W];
               end
            end
         end else begin
            nxt_st.active = st_ff.shadow;
         end
      end
      case (st_ff.state)
         XCFG_IDLE: begin
            if (!sel_n_s) begin
               nxt_st.state = XCFG_WAIT_RISE;
            end
         end
         XCFG_WAIT_RISE: begin
            if (sel_n_s) begin
               nxt_st.state = XCFG_IDLE;
            end else if (rise) begin
               nxt_st.state = XCFG_SHIFT;
            end
         end
         XCFG_SHIFT: begin
            if (sel_n_s) begin
               nxt_st.state = XCFG_IDLE;
            end else if (fall) begin
               // shift direction puts first bit at the lowest index after a full frame
               if (mode_s) begin
                  nxt_st.word = {sdi_s, st_ff.word[XCFG_WORD_W-1:1]};
               end else begin
                  nxt_st.shadow = {sdi_s, st_ff.shadow[XCFG_FRAME_W-1:1]};
                  nxt_st.sout = st_ff.shadow[0];
               end
               nxt_st.fresh = 1'b1;
            end
         end
         default: nxt_st.state = XCFG_IDLE;
      endcase
      for (int o = 0; o < XCFG_NUM_OUT; o++) begin
         if (force_s) begin
            nxt_st.active[o*XCFG_GRP_W +: XCFG_GRP_W] = XCFG_GRP_FORCE;
         end
         nxt_st.off_q[o] = nxt_st.active[o*XCFG_GRP_W+XCFG_OFF_POS];
         nxt_st.oe_q[o] = ~nxt_st.active[o*XCFG_GRP_W+XCFG_OFF_POS];
         nxt_st.sel_q[o*XCFG_IN_W +: XCFG_IN_W] = nxt_st.active[o*XCFG_GRP_W +: XCFG_IN_W];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff.state <= XCFG_IDLE;
         st_ff.sclk_d <= 1'b0;
         st_ff.apply_d <= 1'b0;
         st_ff.fresh <= 1'b0;
         st_ff.shadow <= XCFG_SHADOW_RST;
         st_ff.word <= XCFG_WORD_RST;
         st_ff.active <= XCFG_SHADOW_RST;
         st_ff.sout <= 1'b0;
         st_ff.off_q <= '1;
         st_ff.sel_q <= '0;
         st_ff.oe_q <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign serial_out = st_ff.sout;
   assign out_off = st_ff.off_q;
   assign out_sel = st_ff.sel_q;
   assign out_oe = st_ff.oe_q;
endmodule

// File: tb/xcfg_port_chk.sv
// assertions on the xcfg_port pins
// assumes apply lands within 5 clk_sys
`timescale 1ns/1ps
module xcfg_port_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic select_n,
   input wire logic apply_strobe,
   input wire logic mode,
   input wire logic broadcast_force,
   input wire logic serial_out,
   input wire logic [3:0] out_off,
   input wire logic [3:0] out_oe,
   input wire logic [11:0] out_sel
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_rst; disable iff (1'b0) rst |=> out_off == 4'hF && !out_sel; endproperty
   a_rst: assert property (p_rst) else $error("rst");
   property p_rso; disable iff (1'b0) rst |=> !out_oe && !serial_out; endproperty
   a_rso: assert property (p_rso) else $error("rst oe");
   property p_oe; out_oe == ~out_off; endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_bc; broadcast_force [*5] |-> !out_off && !out_sel; endproperty
   a_bc: assert property (p_bc) else $error("force");
   property p_hold; (!apply_strobe && !broadcast_force) [*6] |=> $stable({out_off, out_sel}); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_sel; select_n [*8] |=> $stable(serial_out); endproperty
   a_sel: assert property (p_sel) else $error("idle");
   property p_fall; $changed(serial_out) |-> $past(sclk, 6) && !$past(sclk, 2); endproperty
   a_fall: assert property (p_fall) else $error("fall");
   property p_one; (mode && !broadcast_force) [*8] |=> $countones(out_off ^ $past(out_off)) < 2; endproperty
   a_one: assert property (p_one) else $error("one");
   c_fr: cover property ($rose(apply_strobe) && !mode);
   c_wd: cover property ($rose(apply_strobe) && mode);
   c_bc: cover property (broadcast_force [*5]);
endmodule
bind xcfg_port xcfg_port_chk u_xcfg_port_chk (.*);

// File: tb/xcfg_master.sv
// serial master model for the xcfg_port link pins
// assumes send is entered at a falling clk_sys edge
`timescale 1ns/1ps
module xcfg_master (
   output logic sclk = 1'b0,
   output logic serial_in = 1'b1,
   output logic select_n = 1'b1
);
   task automatic send(input logic [15:0] d, input int n);
      select_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         #16 sclk = 1'b1; // rise arms the port
         serial_in = d[i]; // lsb first
         #16 sclk = 1'b0; // clock returns low after each bit
      end
      #16 select_n = 1'b1; // deselect before any further rise
      serial_in = ~serial_in; // released line shows no stale bit
   endtask
   // clock pulses while deselected, as a free-running clock would give
   task automatic idle_clock(input int n);
      for (int i = 0; i < n; i++) begin
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
      end
   endtask
endmodule

// File: tb/tb.sv
// bench for xcfg_port: frame, word, broadcast
// assumes the xcfg_master model and bound checker
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
   logic clk_sys = 1'b0, rst = 1'b1, apply_drv = 1'b0, three_wire = 1'b0, mode = 1'b0, broadcast_force = 1'b0;
   logic sclk, serial_in, select_n, serial_out;
   logic [3:0] out_off, out_oe;
   logic [11:0] out_sel;
   wire apply_strobe;
   int err_total = 0, num_checks = 0;
   always #2 clk_sys = ~clk_sys;
   // three-wire hookup: the shared line rises at the end of a frame and doubles as the strobe
   assign apply_strobe = apply_drv | (three_wire & select_n);
   xcfg_master u_xcfg_master (.sclk(sclk), .serial_in(serial_in), .select_n(select_n));
   xcfg_port u_xcfg_port (
      .clk_sys(clk_sys),
      .rst(rst),
      .sclk(sclk),
      .serial_in(serial_in),
      .select_n(select_n),
      .apply_strobe(apply_strobe),
      .mode(mode),
      .broadcast_force(broadcast_force),
      .serial_out(serial_out),
      .out_off(out_off),
      .out_sel(out_sel),
      .out_oe(out_oe)
   );
   task automatic complete_run;
      if (err_total == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // strobe held 3 cycles so the synchroniser cannot miss it
   task automatic step(input logic ap, input logic [3:0] off, input logic [11:0] sel);
      apply_drv = ap;
      repeat (3) @(negedge clk_sys);
      apply_drv = 1'b0;
      repeat (8) @(negedge clk_sys);
      `CHK("off", off, out_off)
      `CHK("sel", sel, out_sel)
      `CHK("oe", ~off, out_oe)
   endtask
   initial begin
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      step(1'b0, 4'hF, 12'h0);
      u_xcfg_master.send(16'h07A5, 16);
      u_xcfg_master.idle_clock(4);
      `CHK("sout", 1'b1, serial_out)
      step(1'b0, 4'hF, 12'h0);
      step(1'b1, 4'h2, 12'h1D5);
      step(1'b1, 4'h2, 12'h1D5);
      mode = 1'b1;
      three_wire = 1'b1;
      repeat (2) @(negedge clk_sys);
      u_xcfg_master.send(16'h002E, 6);
      step(1'b0, 4'h6, 12'h0D5);
      three_wire = 1'b0;
      mode = 1'b0;
      repeat (3) @(negedge clk_sys);
      step(1'b1, 4'h6, 12'h0D5);
      broadcast_force = 1'b1;
      step(1'b0, 4'h0, 12'h0);
      broadcast_force = 1'b0;
      rst = 1'b1;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      step(1'b0, 4'hF, 12'h0);
      `CHK("sout", 1'b0, serial_out)
      complete_run();
   end
   initial begin
      #5000 err_total++;
      complete_run();
   end
endmodule
